// File: rtl/threshold_select_pkg.sv
// threshold_select_pkg: constants and types shared by the supply voltage detector control
package threshold_select_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_PROTECT = 4'h0;
  localparam logic [3:0] OFS_CLOCK = 4'h1;
  localparam logic [3:0] OFS_CONTROL = 4'h2;
  localparam logic [3:0] OFS_FLAGS = 4'h3;
  localparam logic [3:0] OFS_IRQ_EN = 4'h4;
  // protection key
  localparam logic [15:0] PROTECT_KEY = 16'h0096;
  // reset-enable key value
  localparam logic [3:0] RESET_KEY = 4'ha;
  // detector_control field positions
  localparam int POS_SUPPLY = 15;
  localparam int POS_COUNT = 13;
  localparam int POS_THRESH = 8;
  localparam int POS_RKEY = 4;
  localparam int POS_EXT = 3;
  localparam int POS_MODE = 1;
  localparam int POS_EN = 0;
  // detector_clock_control field positions
  localparam int POS_DEBUG_RUN = 8;
  localparam int POS_CLOCK_DIVIDER = 4;
  localparam int POS_CLOCK_SOURCE = 0;
  // detector_flag_register field positions
  localparam int POS_RESULT = 1;
  localparam int POS_FLAG = 0;
  // values after reset
  localparam logic [4:0] THRESH_RST = 5'h1e;
  localparam logic DEBUG_RUN_RST = 1'b1;
  // intermittent periods in detector clock ticks
  localparam logic [9:0] PERIOD_128 = 10'h080;
  localparam logic [9:0] PERIOD_256 = 10'h100;
  localparam logic [9:0] PERIOD_512 = 10'h200;
  // control register image
  typedef struct packed {
    logic supply_select;
    logic [1:0] low_count_select;
    logic [4:0] threshold_select;
    logic [3:0] reset_enable_key;
    logic external_pin_select;
    logic [1:0] interval_mode;
    logic detect_enable;
  } threshold_select_ctrl_s;
  // detector clock control image
  typedef struct packed {
    logic debug_run;
    logic [2:0] clock_divider;
    logic [1:0] clock_source;
  } threshold_select_clk_s;
endpackage : threshold_select_pkg

// File: rtl/threshold_select_sampler.sv
// threshold_select_sampler: comparator power and sample timing on the detector clock
`timescale 1ns/1ns
module threshold_select_sampler (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // control
  input wire logic enable,
  input wire logic [1:0] mode,
  input wire logic det_tick,
  // timing outputs
  output logic power_q,
  output logic sample_q
);
  logic [9:0] cnt_q;
  logic [9:0] period;

  // period from mode; continuous mode samples every tick
  always_comb begin
    unique case (mode)
      2'h1: period = threshold_select_pkg::PERIOD_128;
      2'h2: period = threshold_select_pkg::PERIOD_256;
      2'h3: period = threshold_select_pkg::PERIOD_512;
      2'h0: period = 10'h001;
    endcase
  end

  // comparator powers on one tick ahead and stays on through the sample
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 10'h000;
      power_q <= 1'b0;
      sample_q <= 1'b0;
    end else if (ce) begin
      sample_q <= 1'b0;
      if (!enable) begin
        cnt_q <= 10'h000;
        power_q <= 1'b0;
      end else if (mode == 2'h0) begin
        power_q <= 1'b1;
        sample_q <= det_tick;
        cnt_q <= 10'h000;
      end else if (det_tick) begin
        if (cnt_q >= period - 10'h001) begin
          cnt_q <= 10'h000;
          // a period cut short by a mode change finds the comparator
          // unpowered, so that interval is skipped, not sampled
          sample_q <= power_q;
        end else begin
          cnt_q <= cnt_q + 10'h001;
          power_q <= (cnt_q == period - 10'h002);
        end
      end else if (sample_q) begin
        // power drops only once the sample has been taken
        power_q <= 1'b0;
      end
    end
  end
endmodule : threshold_select_sampler

// File: rtl/threshold_select_counter.sv
// threshold_select_counter: consecutive low-sample counter for intermittent mode
`timescale 1ns/1ns
module threshold_select_counter (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // control
  input wire logic enable,
  input wire logic continuous,
  input wire logic [1:0] count_sel,
  input wire logic sample,
  input wire logic low,
  // event
  output logic event_q
);
  logic [3:0] cnt_q;
  logic [3:0] need;

  // one, two, four or eight consecutive lows
  always_comb begin
    need = 4'h1 << count_sel;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
      event_q <= 1'b0;
    end else if (ce) begin
      event_q <= 1'b0;
      if (!enable) begin
        cnt_q <= 4'h0;
      end else if (sample) begin
        if (!low) begin
          cnt_q <= 4'h0;
        end else if (continuous) begin
          event_q <= 1'b1;
          cnt_q <= 4'h0;
        end else if (cnt_q + 4'h1 >= need) begin
          event_q <= 1'b1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule : threshold_select_counter

// File: rtl/threshold_select_top.sv
// threshold_select_top: supply voltage detector control, registers, interrupt, reset
//
// Summary of operation
// - result reads 0 at or above threshold, 1 below it.
// - interval mode zero runs continuously and updates the result always.
// - continuous low gives interrupt event, or reset when key is 0xa.
// - intermittent modes power comparator each interval, sample once, power off.
// - intermittent event only after the selected count of consecutive lows.
// - count select gives one, two, four or eight; unused when continuous.
// - intermittent period is detector clock over 128, 256 or 512.
// - interrupt function only when key differs from 0xa; event sets flag.
// - interrupt request while flag set and irq enable is one.
// - flag stays set on recovery; cleared only by writing one.
// - with key 0xa reset issues when the flag would be set.
// - after issuing reset the detector switches to continuous and runs on.
// - during detector reset the external sense pin stays routed.
// - reset held until result returns to 0, then released.
// - during detector reset clock control bits return to initial values.
// - supply, threshold, pin select, key and enable keep their values.
// - mode and count cleared, irq enable cleared, flag kept.
// - continuous mode keeps detecting regardless of system clock state; here detection runs on clk_sys and stops while ce is low.
`timescale 1ns/1ns
module threshold_select_top (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  // detector side
  input wire logic det_tick,
  input wire logic comp_low,
  input wire logic external_sense_pin_0,
  input wire logic external_sense_pin_1,
  output logic comp_power_q,
  output logic [4:0] comp_threshold_q,
  output logic comp_supply_q,
  output logic comp_ext_pin_q,
  output logic sense_pin_route_q,
  // system side
  output logic irq_q,
  output logic detector_reset_q,
  output logic [5:0] clk_cfg_q
);
  // ==========================================================
  // state
  threshold_select_pkg::threshold_select_ctrl_s ctrl_q;
  threshold_select_pkg::threshold_select_clk_s clkc_q;
  logic unlocked_q;
  logic result_q;
  logic flag_q;
  logic irq_en_q;
  logic sample;
  logic det_event;
  logic wr_prot;
  logic wr_clk;
  logic wr_ctrl;
  logic wr_flag;
  logic wr_ien;
  logic reset_mode;
  logic irq_mode;
  logic sense_unused;

  // ==========================================================
  // timing of one detection, counted in system clock cycles
  // c0: detector tick seen while detection is enabled
  // c1: sampler pulse; the comparator is powered in this cycle
  // c2: result loaded, counter may raise its one-cycle event
  // c3: flag set, and the detector reset raised too in reset mode
  // c4: interrupt request follows the flag by one more cycle
  // every output is registered, so the request lags the flag
  // by one cycle; glitch-free outputs cost one cycle of latency
  //
  // hazards that shaped the code
  // - a flag clear in the same cycle as a new event loses, so
  //   a low detection is never dropped by a late acknowledge
  // - writes to the protected registers are ignored silently
  //   while locked, just as software expects from a lock
  // - the detector reset freezes control writes; software must
  //   re-initialise after it falls to get its old mode back
  // - the clock enable freezes every register here, including
  //   the sampler and the counter, so no tick is half-counted
  //
  // limitations
  // - the count select is written only while the interval mode
  //   already is intermittent; set the mode first, then count
  // - clearing detect_enable forces the result to zero at once
  //   and restarts the consecutive-low count
  // - the comparator is taken as settled one tick after power-on;
  //   a slower comparator needs a longer lead in the sampler
  // - the external sense pins are analog and bypass this logic;
  //   only the routing request leaves the block

  // ==========================================================
  // write decode; protected registers need the unlock key
  assign wr_prot = reg_wr && reg_addr == threshold_select_pkg::OFS_PROTECT;
  assign wr_clk = reg_wr && unlocked_q && reg_addr == threshold_select_pkg::OFS_CLOCK;
  assign wr_ctrl = reg_wr && unlocked_q && reg_addr == threshold_select_pkg::OFS_CONTROL;
  assign wr_flag = reg_wr && reg_addr == threshold_select_pkg::OFS_FLAGS;
  assign wr_ien = reg_wr && reg_addr == threshold_select_pkg::OFS_IRQ_EN;
  assign reset_mode = ctrl_q.reset_enable_key == threshold_select_pkg::RESET_KEY;
  assign irq_mode = !reset_mode;
  // pins are read by the analog comparator, not by this logic
  assign sense_unused = external_sense_pin_0 ^ external_sense_pin_1;

  // ==========================================================
  // protection unlock: key opens, any other value closes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      unlocked_q <= 1'b0;
    end else if (ce && wr_prot) begin
      unlocked_q <= reg_wdata == threshold_select_pkg::PROTECT_KEY;
    end
  end

  // ==========================================================
  // sample timing and consecutive counting
  threshold_select_sampler u_sampler (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .enable(ctrl_q.detect_enable),
    .mode(ctrl_q.interval_mode),
    .det_tick(det_tick),
    .power_q(comp_power_q),
    .sample_q(sample)
  );

  threshold_select_counter u_counter (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .enable(ctrl_q.detect_enable),
    .continuous(ctrl_q.interval_mode == 2'h0),
    .count_sel(ctrl_q.low_count_select),
    .sample(sample),
    .low(comp_low),
    .event_q(det_event)
  );

  // ==========================================================
  // detection result, loaded on each sample
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      result_q <= 1'b0;
    end else if (ce) begin
      if (!ctrl_q.detect_enable) begin
        result_q <= 1'b0;
      end else if (sample) begin
        result_q <= comp_low;
      end
    end
  end

  // ==========================================================
  // detector reset: raised on event, held until result clears
  // a fresh event while held simply keeps the request up
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      detector_reset_q <= 1'b0;
    end else if (ce) begin
      if (det_event && reset_mode) begin
        detector_reset_q <= 1'b1;
      end else if (detector_reset_q && !result_q) begin
        detector_reset_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control register; during detector reset mode and count clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q <= '0;
      ctrl_q.threshold_select <= threshold_select_pkg::THRESH_RST;
    end else if (ce) begin
      if (detector_reset_q || (det_event && reset_mode)) begin
        // others retained so detection carries on
        ctrl_q.interval_mode <= 2'h0;
        ctrl_q.low_count_select <= 2'h0;
      end else if (wr_ctrl) begin
        ctrl_q.supply_select <= reg_wdata[threshold_select_pkg::POS_SUPPLY];
        // count select is only writable in intermittent mode
        if (ctrl_q.interval_mode != 2'h0) begin
          ctrl_q.low_count_select <= reg_wdata[threshold_select_pkg::POS_COUNT +: 2];
        end
        ctrl_q.threshold_select <= reg_wdata[threshold_select_pkg::POS_THRESH +: 5];
        ctrl_q.reset_enable_key <= reg_wdata[threshold_select_pkg::POS_RKEY +: 4];
        ctrl_q.external_pin_select <= reg_wdata[threshold_select_pkg::POS_EXT];
        ctrl_q.interval_mode <= reg_wdata[threshold_select_pkg::POS_MODE +: 2];
        ctrl_q.detect_enable <= reg_wdata[threshold_select_pkg::POS_EN];
      end
    end
  end

  // ==========================================================
  // clock control register; returns to initial during detector reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clkc_q <= '0;
      clkc_q.debug_run <= threshold_select_pkg::DEBUG_RUN_RST;
    end else if (ce) begin
      if (detector_reset_q) begin
        clkc_q <= '0;
        clkc_q.debug_run <= threshold_select_pkg::DEBUG_RUN_RST;
      end else if (wr_clk) begin
        clkc_q.debug_run <= reg_wdata[threshold_select_pkg::POS_DEBUG_RUN];
        clkc_q.clock_divider <= reg_wdata[threshold_select_pkg::POS_CLOCK_DIVIDER +: 3];
        clkc_q.clock_source <= reg_wdata[threshold_select_pkg::POS_CLOCK_SOURCE +: 2];
      end
    end
  end

  // ==========================================================
  // sticky flag: set wins over a write-one clear
  // the clear is refused while the detector reset is up
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else if (ce) begin
      if (det_event) begin
        flag_q <= 1'b1;
      end else if (wr_flag && reg_wdata[threshold_select_pkg::POS_FLAG]
                   && !detector_reset_q) begin
        flag_q <= 1'b0;
      end
    end
  end

  // interrupt enable, cleared during detector reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_en_q <= 1'b0;
    end else if (ce) begin
      if (detector_reset_q) begin
        irq_en_q <= 1'b0;
      end else if (wr_ien) begin
        irq_en_q <= reg_wdata[0];
      end
    end
  end

  // interrupt request only in interrupt mode
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= flag_q && irq_en_q && irq_mode;
    end
  end

  // ==========================================================
  // comparator configuration and pin routing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      comp_threshold_q <= threshold_select_pkg::THRESH_RST;
      comp_supply_q <= 1'b0;
      comp_ext_pin_q <= 1'b0;
      sense_pin_route_q <= 1'b0;
      clk_cfg_q <= 6'h00;
    end else if (ce) begin
      comp_threshold_q <= ctrl_q.threshold_select;
      comp_supply_q <= ctrl_q.supply_select;
      comp_ext_pin_q <= ctrl_q.external_pin_select;
      // route holds through detector reset so pin sensing goes on
      sense_pin_route_q <= ctrl_q.supply_select
                           && ctrl_q.detect_enable;
      clk_cfg_q <= {clkc_q.debug_run, clkc_q.clock_divider,
                    clkc_q.clock_source};
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 16'h0000;
    end else if (ce) begin
      reg_rdata_q <= 16'h0000;
      if (reg_rd) begin
        unique case (reg_addr)
          threshold_select_pkg::OFS_PROTECT: reg_rdata_q <= {15'h0000, unlocked_q};
          threshold_select_pkg::OFS_CLOCK: reg_rdata_q <= {7'h00, clkc_q.debug_run,
            1'b0, clkc_q.clock_divider, 2'h0, clkc_q.clock_source};
          threshold_select_pkg::OFS_CONTROL: reg_rdata_q <= ctrl_q;
          threshold_select_pkg::OFS_FLAGS: reg_rdata_q <= {14'h0000,
            result_q, flag_q};
          threshold_select_pkg::OFS_IRQ_EN: reg_rdata_q <= {15'h0000, irq_en_q};
          default: reg_rdata_q <= {15'h0000, sense_unused & 1'b0};
        endcase
      end
    end
  end
endmodule : threshold_select_top

// File: tb/threshold_select_top_props.sv
// threshold_select_top_props: port-level assertions for the detector control
`timescale 1ns/1ns
module threshold_select_top_props (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // detector and system side
  input wire logic comp_low,
  input wire logic comp_power_q,
  input wire logic [4:0] comp_threshold_q,
  input wire logic comp_supply_q,
  input wire logic comp_ext_pin_q,
  input wire logic sense_pin_route_q,
  input wire logic irq_q,
  input wire logic detector_reset_q,
  input wire logic [5:0] clk_cfg_q
);
  // ==================================================
  // helpers: writes that may legally change the watched state
  logic clr_hit;
  logic ctl_wr;
  assign clr_hit = reg_wr && (reg_addr == threshold_select_pkg::OFS_FLAGS ||
    reg_addr == threshold_select_pkg::OFS_IRQ_EN);
  assign ctl_wr = reg_wr && reg_addr == threshold_select_pkg::OFS_CONTROL;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_rst_steady;
    detector_reset_q ##1 detector_reset_q;
  endsequence
  // five cycles of a powered low cover the last sample that loaded
  // the result, so no normal sample can release the reset
  sequence s_low_held;
    (comp_low && comp_power_q) [*5];
  endsequence
  property p_irq_hold;
    irq_q && !clr_hit && !$past(clr_hit) && !detector_reset_q |=> irq_q;
  endproperty
  property p_ien_off;
    reg_wr && reg_addr == threshold_select_pkg::OFS_IRQ_EN && !reg_wdata[0]
      |-> ##2 !irq_q;
  endproperty
  property p_rst_no_irq;
    $rose(detector_reset_q) |-> ##2 !irq_q;
  endproperty
  property p_clk_init;
    s_rst_steady |=> clk_cfg_q == 6'h20;
  endproperty
  property p_route;
    s_rst_steady ##0 comp_supply_q |-> sense_pin_route_q;
  endproperty
  property p_keep;
    s_rst_steady ##0 (!$past(ctl_wr) && !$past(ctl_wr, 2)) |->
      $stable(comp_threshold_q) && $stable(comp_supply_q) &&
      $stable(comp_ext_pin_q);
  endproperty
  property p_cont;
    detector_reset_q [*8] |-> comp_power_q;
  endproperty
  property p_hold;
    s_low_held ##0 detector_reset_q |=> detector_reset_q;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without a clear");
  a_ien_off: assert property (p_ien_off)
    else $error("irq stayed up while disabled");
  a_rst_no_irq: assert property (p_rst_no_irq)
    else $error("irq active in detector reset");
  a_clk_init: assert property (p_clk_init)
    else $error("clock config not initial in reset");
  a_route: assert property (p_route)
    else $error("sense pin route lost in reset");
  a_keep: assert property (p_keep)
    else $error("comparator selection changed in reset");
  a_cont: assert property (p_cont)
    else $error("comparator not powered in reset");
  a_hold: assert property (p_hold)
    else $error("reset released while low");
endmodule : threshold_select_top_props

// File: tb/threshold_select_far_model.sv
// threshold_select_far_model: detector clock ticks and comparator output
`timescale 1ns/1ns
module threshold_select_far_model #(
  parameter int TICK_DIV = 4
) (
  // clocking
  input wire logic clk_sys,
  input wire logic reset,
  // comparator
  input wire logic comp_power_q,
  input wire logic low_lvl,
  output logic det_tick,
  output logic comp_low
);
  int cnt_q;
  logic junk_q;
  // ticks run free; an unpowered comparator shows a toggling level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q <= 0;
      junk_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
      junk_q <= ~junk_q;
    end
  end
  assign det_tick = (cnt_q == TICK_DIV - 1);
  assign comp_low = comp_power_q ? low_lvl : junk_q;
endmodule : threshold_select_far_model

// File: tb/tb.sv
// tb: self-checking bench for the detector control
`timescale 1ns/1ns
module tb;
  localparam int TICK_DIV = 4;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic low_lvl = 1'b0;
  logic [15:0] reg_rdata_q;
  logic det_tick, comp_low, comp_power_q, comp_supply_q, comp_ext_pin_q;
  logic [4:0] comp_threshold_q;
  logic sense_pin_route_q, irq_q, detector_reset_q;
  logic [5:0] clk_cfg_q;
  int failures = 0;
  int checks_done = 0;
  // ==================================================
  // clock and instances
  always #5 clk_sys = ~clk_sys;
  threshold_select_top u_threshold_select_top (
    .clk_sys(clk_sys), .reset(reset), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .det_tick(det_tick),
    .comp_low(comp_low), .external_sense_pin_0(1'b0),
    .external_sense_pin_1(1'b0), .comp_power_q(comp_power_q),
    .comp_threshold_q(comp_threshold_q), .comp_supply_q(comp_supply_q),
    .comp_ext_pin_q(comp_ext_pin_q), .sense_pin_route_q(sense_pin_route_q),
    .irq_q(irq_q), .detector_reset_q(detector_reset_q),
    .clk_cfg_q(clk_cfg_q));
  threshold_select_far_model #(.TICK_DIV(TICK_DIV)) u_threshold_select_far_model (
    .clk_sys(clk_sys), .reset(reset), .comp_power_q(comp_power_q),
    .low_lvl(low_lvl), .det_tick(det_tick), .comp_low(comp_low));
  // ==================================================
  // shared bus and compare tasks
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e,
    input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, e, reg_rdata_q);
  endtask : rd
  // bounded wait on irq (0), detector reset (1) or comparator power (2)
  task automatic wait_on(input int sel, input logic v, output int n);
    n = 0;
    while ((sel == 0 ? irq_q : sel == 1 ? detector_reset_q : comp_power_q)
      !== v) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 20000) begin
        failures++;
        $display("[ERR] wait %0d expected %b seen timeout", sel, v);
        print_verdict();
      end
    end
  endtask : wait_on
  // ==================================================
  // scenarios
  task automatic t_init();
    wr(threshold_select_pkg::OFS_CONTROL, 16'h1e01);
    rd(threshold_select_pkg::OFS_CONTROL, 16'h1e00, "locked control");
    rd(threshold_select_pkg::OFS_CLOCK, 16'h0100, "clock reset");
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0000, "flags reset");
    rd(threshold_select_pkg::OFS_IRQ_EN, 16'h0000, "irq enable reset");
    rd(4'hf, 16'h0000, "unmapped");
    chk("clk_cfg_q", 16'h0020, clk_cfg_q);
    wr(threshold_select_pkg::OFS_PROTECT, 16'h0096);
    rd(threshold_select_pkg::OFS_PROTECT, 16'h0001, "unlocked");
    $display("test init done");
  endtask : t_init
  task automatic t_cont();
    int n;
    wr(threshold_select_pkg::OFS_IRQ_EN, 16'h0001);
    wr(threshold_select_pkg::OFS_CONTROL, 16'h1e01);
    repeat (8 * TICK_DIV) @(posedge clk_sys);
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0000, "normal level");
    @(posedge clk_sys);
    low_lvl <= 1'b1;
    wait_on(0, 1'b1, n);
    chk("irq latency", 16'h0001, 16'(n <= TICK_DIV + 5));
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0003, "low detected");
    @(posedge clk_sys);
    low_lvl <= 1'b0;
    repeat (4 * TICK_DIV) @(posedge clk_sys);
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0001, "flag after recovery");
    wr(threshold_select_pkg::OFS_IRQ_EN, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq masked", 16'h0000, irq_q);
    wr(threshold_select_pkg::OFS_IRQ_EN, 16'h0001);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq unmasked", 16'h0001, irq_q);
    wr(threshold_select_pkg::OFS_FLAGS, 16'h0001);
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0000, "flag cleared");
    $display("test continuous done");
  endtask : t_cont
  // period is measured as pulse width plus gap of the comparator power
  task automatic t_period();
    int n, m;
    for (int md = 1; md <= 3; md++) begin
      wr(threshold_select_pkg::OFS_CONTROL, 16'h1e01 | 16'(md << 1));
      wait_on(2, 1'b1, n);
      wait_on(2, 1'b0, n);
      wait_on(2, 1'b1, n);
      wait_on(2, 1'b0, m);
      wait_on(2, 1'b1, n);
      chk("interval", 16'((64 * TICK_DIV) << md), 16'(m + n));
    end
    $display("test period done");
  endtask : t_period
  task automatic t_count();
    int n, k;
    for (int sc = 0; sc <= 3; sc++) begin
      wr(threshold_select_pkg::OFS_CONTROL, 16'h1e03 | 16'(sc << 13));
      wr(threshold_select_pkg::OFS_FLAGS, 16'h0001);
      wait_on(2, 1'b1, n);
      wait_on(2, 1'b0, n);
      @(posedge clk_sys);
      low_lvl <= 1'b1;
      k = 0;
      while (irq_q !== 1'b1 && k < 9) begin
        wait_on(2, 1'b1, n);
        wait_on(2, 1'b0, n);
        k++;
        repeat (8) @(posedge clk_sys);
        #1;
      end
      chk("low samples", 16'(1 << sc), 16'(k));
      @(posedge clk_sys);
      low_lvl <= 1'b0;
    end
    $display("test count done");
  endtask : t_count
  task automatic t_reset();
    int n;
    wr(threshold_select_pkg::OFS_CLOCK, 16'h0053);
    wr(threshold_select_pkg::OFS_FLAGS, 16'h0001);
    wr(threshold_select_pkg::OFS_CONTROL, 16'hb0a3);
    @(posedge clk_sys);
    low_lvl <= 1'b1;
    wait_on(1, 1'b1, n);
    repeat (10) @(posedge clk_sys);
    #1 chk("irq in reset", 16'h0000, irq_q);
    chk("clk_cfg_q", 16'h0020, clk_cfg_q);
    chk("route", 16'h0001, sense_pin_route_q);
    chk("power", 16'h0001, comp_power_q);
    chk("threshold", 16'h0010, comp_threshold_q);
    chk("supply", 16'h0001, comp_supply_q);
    rd(threshold_select_pkg::OFS_CONTROL, 16'h90a1, "control in reset");
    rd(threshold_select_pkg::OFS_IRQ_EN, 16'h0000, "irq enable in reset");
    wr(threshold_select_pkg::OFS_FLAGS, 16'h0001);
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0003, "flag in reset");
    rd(threshold_select_pkg::OFS_CLOCK, 16'h0100, "clock in reset");
    @(posedge clk_sys);
    low_lvl <= 1'b0;
    wait_on(1, 1'b0, n);
    rd(threshold_select_pkg::OFS_FLAGS, 16'h0001, "flag after reset");
    wr(threshold_select_pkg::OFS_PROTECT, 16'h0096);
    wr(threshold_select_pkg::OFS_CONTROL, 16'h1e00);
    wr(threshold_select_pkg::OFS_PROTECT, 16'h0000);
    rd(threshold_select_pkg::OFS_CONTROL, 16'h1e00, "stopped");
    $display("test reset done");
  endtask : t_reset
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_init();
    t_cont();
    t_period();
    t_count();
    t_reset();
    print_verdict();
  end
endmodule : tb
bind threshold_select_top threshold_select_top_props u_threshold_select_top_props (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .comp_low(comp_low),
  .comp_power_q(comp_power_q), .comp_threshold_q(comp_threshold_q),
  .comp_supply_q(comp_supply_q), .comp_ext_pin_q(comp_ext_pin_q),
  .sense_pin_route_q(sense_pin_route_q), .irq_q(irq_q),
  .detector_reset_q(detector_reset_q), .clk_cfg_q(clk_cfg_q));
